/* logic/seg_consts.svh */
// seg_consts.svh: offsets, field positions and reset values for the error gating block
// assumes inclusion by bare name from the design module and the testbench
`ifndef SEG_CONSTS_SVH
`define SEG_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SEG_ADDR_W           8
`define SEG_OFS_IRQ_ENABLE   8'h00
`define SEG_OFS_FLAGS        8'h04
`define SEG_OFS_MODE         8'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SEG_BIT_BIT_FAULT    4
`define SEG_BIT_DESYNC       3
`define SEG_BIT_PARITY       2
`define SEG_BIT_TIMEOUT      1
`define SEG_ENA_MASK         32'h0000_001e
`define SEG_MODE_MASTER      0
`define SEG_MODE_PINS_LSB    1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SEG_ENA_RESET        4'h0
`define SEG_MODE_RESET       3'h0

`endif

/* logic/seg_irq_gate.sv */
// seg_irq_gate.sv: enable register that gates four error flags onto an interrupt line
// assumes the flag register lives outside and presents its flags synchronously on mclk
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "seg_consts.svh"

// Behaviour
// - bit fault flag raises interrupt only while enable bit 4 is set
// - slave desync flag raises interrupt only while enable bit 3 is set
// - desync monitor and its interrupt live only as master in 4-pin-ena or 5-pin
// - parity fault flag raises interrupt only while enable bit 2 is set
// - handshake timeout flag raises interrupt only while enable bit 1 is set
module seg_irq_gate (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_b,
    // register port
    input  wire seg_pkg::seg_req_s req,
    output logic [31:0]            rdata,
    // error flags from the flag register
    input  wire seg_pkg::seg_err_s err_flags,
    // desync monitor enable toward the detector
    output logic                   desync_monitor_on,
    // interrupt request
    output logic                   err_irq
);

    // ----------------------------------------------------------------
    // monitor qualification
    // ----------------------------------------------------------------
    function automatic logic monitor_active(input logic [2:0] mode);
        seg_pkg::seg_pins_e pins;
        pins = seg_pkg::seg_pins_e'(mode[2:1]);
        return mode[`SEG_MODE_MASTER] &&
               (pins == seg_pkg::SEG_PINS_4_ENA || pins == seg_pkg::SEG_PINS_5);
    endfunction : monitor_active

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    seg_pkg::seg_err_s ena;
    seg_pkg::seg_err_s next_ena;
    logic [2:0]        mode;
    logic [2:0]        next_mode;
    logic [31:0]       next_rdata;
    logic              next_irq;
    logic              next_mon;
    seg_pkg::seg_err_s gated;

    always_comb begin
        next_ena  = ena;
        next_mode = mode;
        if (req.wr) begin
            if (req.addr == `SEG_OFS_IRQ_ENABLE) begin
                next_ena.bit_fault         = req.wdata[`SEG_BIT_BIT_FAULT];
                next_ena.slave_desync      = req.wdata[`SEG_BIT_DESYNC];
                next_ena.parity_fault      = req.wdata[`SEG_BIT_PARITY];
                next_ena.handshake_timeout = req.wdata[`SEG_BIT_TIMEOUT];
            end else if (req.addr == `SEG_OFS_MODE) begin
                next_mode = req.wdata[2:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // gating
    // ----------------------------------------------------------------
    always_comb begin
        next_mon                 = monitor_active(next_mode);
        gated.bit_fault          = err_flags.bit_fault & ena.bit_fault;
        gated.slave_desync       = err_flags.slave_desync & ena.slave_desync
                                   & desync_monitor_on;
        gated.parity_fault       = err_flags.parity_fault & ena.parity_fault;
        gated.handshake_timeout  = err_flags.handshake_timeout
                                   & ena.handshake_timeout;
        next_irq                 = |gated;
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (req.rd) begin
            if (req.addr == `SEG_OFS_IRQ_ENABLE) begin
                next_rdata[`SEG_BIT_BIT_FAULT] = ena.bit_fault;
                next_rdata[`SEG_BIT_DESYNC]    = ena.slave_desync;
                next_rdata[`SEG_BIT_PARITY]    = ena.parity_fault;
                next_rdata[`SEG_BIT_TIMEOUT]   = ena.handshake_timeout;
            end else if (req.addr == `SEG_OFS_FLAGS) begin
                next_rdata[`SEG_BIT_BIT_FAULT] = err_flags.bit_fault;
                next_rdata[`SEG_BIT_DESYNC]    = err_flags.slave_desync;
                next_rdata[`SEG_BIT_PARITY]    = err_flags.parity_fault;
                next_rdata[`SEG_BIT_TIMEOUT]   = err_flags.handshake_timeout;
            end else if (req.addr == `SEG_OFS_MODE) begin
                next_rdata[2:0] = mode;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ena               <= `SEG_ENA_RESET;
            mode              <= `SEG_MODE_RESET;
            rdata             <= 32'h0000_0000;
            err_irq           <= 1'b0;
            desync_monitor_on <= 1'b0;
        end else begin
            ena               <= next_ena;
            mode              <= next_mode;
            rdata             <= next_rdata;
            err_irq           <= next_irq;
            desync_monitor_on <= next_mon;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence bit_cause_s;
        err_flags.bit_fault && ena.bit_fault;
    endsequence

    bit_fault_irq_a: assert property (@(posedge mclk) disable iff (!rst_b)
        bit_cause_s |=> err_irq) else $error("bit fault not raised");

    desync_irq_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (err_flags.slave_desync && ena.slave_desync && desync_monitor_on) |=> err_irq)
        else $error("desync not raised");

    desync_mode_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (!desync_monitor_on && !err_flags.bit_fault && !err_flags.parity_fault
         && !err_flags.handshake_timeout) |=> !err_irq)
        else $error("desync irq outside its modes");

    parity_irq_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (err_flags.parity_fault && ena.parity_fault) |=> err_irq)
        else $error("parity fault not raised");

    timeout_irq_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (err_flags.handshake_timeout && ena.handshake_timeout) |=> err_irq)
        else $error("timeout not raised");

    irq_masked_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (ena == 4'h0) |=> !err_irq) else $error("irq with all enables off");

    enable_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (req.wr && req.addr == `SEG_OFS_IRQ_ENABLE)
        |=> ena == $past(req.wdata[4:1])) else $error("enable write lost");

    readback_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (req.rd && req.addr == `SEG_OFS_IRQ_ENABLE)
        |=> rdata == {27'h0, $past(ena), 1'b0}) else $error("enable readback wrong");

    // ----------------------------------------------------------------
    // checks: a disabled flag stays off the line
    // ----------------------------------------------------------------
    bit_fault_mask_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (err_flags.bit_fault && !ena.bit_fault && !err_flags.slave_desync
         && !err_flags.parity_fault && !err_flags.handshake_timeout) |=> !err_irq)
        else $error("bit fault raised while disabled");

    desync_mask_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (err_flags.slave_desync && !ena.slave_desync && !err_flags.bit_fault
         && !err_flags.parity_fault && !err_flags.handshake_timeout) |=> !err_irq)
        else $error("desync raised while disabled");

    desync_mode_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (err_flags.slave_desync && ena.slave_desync && !desync_monitor_on
         && !err_flags.bit_fault && !err_flags.parity_fault
         && !err_flags.handshake_timeout) |=> !err_irq)
        else $error("desync raised with monitor off");

    parity_mask_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (err_flags.parity_fault && !ena.parity_fault && !err_flags.bit_fault
         && !err_flags.slave_desync && !err_flags.handshake_timeout) |=> !err_irq)
        else $error("parity fault raised while disabled");

    timeout_mask_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (err_flags.handshake_timeout && !ena.handshake_timeout && !err_flags.bit_fault
         && !err_flags.slave_desync && !err_flags.parity_fault) |=> !err_irq)
        else $error("timeout raised while disabled");

    irq_exact_a: assert property (@(posedge mclk) disable iff (!rst_b)
        1'b1 |=> err_irq == $past((err_flags.bit_fault && ena.bit_fault)
            || (err_flags.slave_desync && ena.slave_desync && desync_monitor_on)
            || (err_flags.parity_fault && ena.parity_fault)
            || (err_flags.handshake_timeout && ena.handshake_timeout)))
        else $error("irq not the or of gated flags");

    // ----------------------------------------------------------------
    // checks: register port
    // ----------------------------------------------------------------
    sequence mode_write_s;
        req.wr && req.addr == `SEG_OFS_MODE;
    endsequence

    sequence stray_write_s;
        req.wr && req.addr != `SEG_OFS_IRQ_ENABLE && req.addr != `SEG_OFS_MODE;
    endsequence

    mode_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
        mode_write_s |=> mode == $past(req.wdata[2:0])) else $error("mode write lost");

    monitor_mode_a: assert property (@(posedge mclk) disable iff (!rst_b)
        desync_monitor_on == (mode[`SEG_MODE_MASTER]
                              && (mode[2:1] == 2'h2 || mode[2:1] == 2'h3)))
        else $error("monitor out of step with mode");

    stray_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
        stray_write_s |=> $stable(ena) && $stable(mode)) else $error("stray write landed");

    enable_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !(req.wr && req.addr == `SEG_OFS_IRQ_ENABLE) |=> $stable(ena))
        else $error("enables moved without a write");

    flag_readback_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (req.rd && req.addr == `SEG_OFS_FLAGS)
        |=> rdata == {27'h0, $past(err_flags), 1'b0}) else $error("flag readback wrong");

    mode_readback_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (req.rd && req.addr == `SEG_OFS_MODE)
        |=> rdata == {29'h0, $past(mode)}) else $error("mode readback wrong");

    read_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !req.rd |=> rdata == 32'h0000_0000) else $error("read data outside read cycle");

endmodule : seg_irq_gate

/* logic/seg_pkg.sv */
// seg_pkg.sv: types for the error interrupt gating block
// assumes compilation ahead of the design module and the testbench, which use its types
package seg_pkg;

    // ----------------------------------------------------------------
    // pin configuration
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SEG_PINS_3,
        SEG_PINS_4_CS,
        SEG_PINS_4_ENA,
        SEG_PINS_5
    } seg_pins_e;

    // ----------------------------------------------------------------
    // error flags, and their enables, in the same layout
    // ----------------------------------------------------------------
    typedef struct packed {
        logic bit_fault;
        logic slave_desync;
        logic parity_fault;
        logic handshake_timeout;
    } seg_err_s;

    // ----------------------------------------------------------------
    // register port request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } seg_req_s;

endpackage : seg_pkg

/* verif/tb_seg_irq_gate.sv */
// tb_seg_irq_gate.sv: self-checking bench for the error interrupt gating block
// assumes seg_pkg compiled first and seg_consts.svh on the include path
`timescale 1ns/1ps
`include "seg_consts.svh"

module tb_seg_irq_gate;
    logic              mclk;
    logic              rst_b;
    seg_pkg::seg_req_s req;
    logic [31:0]       rdata;
    seg_pkg::seg_err_s err_flags;
    logic              desync_monitor_on;
    logic              err_irq;
    int                n_mismatch;
    int                checks_done;
    logic [3:0]        ena;
    logic [2:0]        mode;

    seg_irq_gate seg_irq_gate_i (
        .mclk              (mclk),
        .rst_b             (rst_b),
        .req               (req),
        .rdata             (rdata),
        .err_flags         (err_flags),
        .desync_monitor_on (desync_monitor_on),
        .err_irq           (err_irq)
    );

    // ----------------------------------------------------------------
    // clock, checks and bus tasks
    // ----------------------------------------------------------------
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk) req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk) req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk) req.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd

    function automatic logic exp_irq(logic [3:0] e, logic [3:0] f, logic [2:0] m);
        logic mon;
        mon = m[0] && (m[2:1] >= 2'h2);
        return |(e & f & {1'b1, mon, 2'b11});
    endfunction : exp_irq

    // set mode, enables and flags, then check the gated line
    task automatic apply(input logic [2:0] m, input logic [31:0] e, input logic [3:0] f);
        wr(`SEG_OFS_MODE, {29'h0, m});
        wr(`SEG_OFS_IRQ_ENABLE, e);
        @(posedge mclk) err_flags <= f;
        repeat (3) @(posedge mclk);
        #1;
        chk(desync_monitor_on, m[0] && (m[2:1] >= 2'h2));
        chk(err_irq, exp_irq(e[4:1], f, m));
        rd(`SEG_OFS_IRQ_ENABLE, e & `SEG_ENA_MASK);
        rd(`SEG_OFS_FLAGS, {27'h0, f, 1'b0});
        rd(`SEG_OFS_MODE, {29'h0, m});
    endtask : apply

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        #(25 * 4000);
        n_mismatch++;
        close_out();
    end

    initial begin
        n_mismatch = 0;
        checks_done = 0;
        rst_b = 1'b0;
        req = '0;
        err_flags = '0;
        void'($urandom(32'hb700_5ef7));
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        #1 chk({err_irq, desync_monitor_on}, 2'h0);
        wr(8'h3c, 32'hffff_ffff);
        rd(`SEG_OFS_IRQ_ENABLE, 32'h0000_0000);
        rd(8'h3c, 32'h0000_0000);
        // desync flag alone across every mode
        for (int i = 0; i < 8; i++) apply(3'(i), 32'h0000_0008, 4'h4);
        // each flag with its enable on then off
        for (int b = 0; b < 4; b++) begin
            apply(3'h7, 32'h0000_0002 << b, 4'h1 << b);
            apply(3'h7, 32'h0000_001e ^ (32'h0000_0002 << b), 4'h1 << b);
        end
        for (int n = 0; n < 40; n++) begin
            ena = 4'($urandom());
            mode = 3'($urandom());
            apply(mode, $urandom() | {27'h0, ena, 1'b0}, 4'($urandom()));
        end
        rd(8'h0c, 32'h0000_0000);
        close_out();
    end
endmodule : tb_seg_irq_gate
